// ---- include/ir_rx_pkg.sv ----
package ir_rx_pkg;

	// ----------------------------------------
	// Register map (byte addresses in the SFR space)
	// ----------------------------------------
	localparam logic [15:0] ADDR_RC_CONTROL     = 16'hff60;
	localparam logic [15:0] ADDR_RC_SHIFT       = 16'hff61;
	localparam logic [15:0] ADDR_RC_BYTE_DATA   = 16'hff62;
	localparam logic [15:0] ADDR_RC_BIT_COUNT   = 16'hff63;
	localparam logic [15:0] ADDR_GUIDE_HIGH_MIN = 16'hff64;
	localparam logic [15:0] ADDR_GUIDE_HIGH_MAX = 16'hff65;
	localparam logic [15:0] ADDR_DATA_LOW_MIN   = 16'hff66;
	localparam logic [15:0] ADDR_DATA_LOW_MAX   = 16'hff67;
	localparam logic [15:0] ADDR_ZERO_HIGH_MIN  = 16'hff68;
	localparam logic [15:0] ADDR_ZERO_HIGH_MAX  = 16'hff69;
	localparam logic [15:0] ADDR_ONE_HIGH_MIN   = 16'hff6a;
	localparam logic [15:0] ADDR_ONE_HIGH_MAX   = 16'hff6b;
	localparam logic [15:0] ADDR_END_WIDTH      = 16'hff6c;

	// ----------------------------------------
	// Control register fields and reset values
	// ----------------------------------------
	localparam int          BIT_RECEIVE_ENABLE  = 7;
	localparam int          BIT_NOISE_WIDTH_SEL = 6;
	localparam int          BIT_CLOCK_HALVE     = 5;
	localparam int          BIT_INPUT_INVERT    = 4;
	localparam logic [7:0]  CONTROL_WMASK       = 8'hf3;
	localparam logic [7:0]  REG_RESET           = 8'h00;
	localparam logic [2:0]  COUNT_ZERO          = 3'h0;
	localparam logic [2:0]  COUNT_FULL          = 3'h7;
	localparam logic [7:0]  WIDTH_MAX           = 8'hff;

	// Main clock prescaler: tick every 64/128/256 ref_clk cycles
	localparam logic [1:0]  SRC_DIV64           = 2'h0;
	localparam logic [1:0]  SRC_DIV128          = 2'h1;
	localparam logic [1:0]  SRC_DIV256          = 2'h2;
	localparam logic [1:0]  SRC_SUB             = 2'h3;
	localparam int          IDX_DIV64           = 5;
	localparam int          IDX_DIV128          = 6;
	localparam int          IDX_DIV256          = 7;

	typedef enum logic [1:0] {
		ST_GUIDE    = 2'b00,
		ST_DATA_LOW = 2'b01,
		ST_DATA_HI  = 2'b11,
		ST_END_WAIT = 2'b10
	} rx_state_t;

endpackage

// ---- core/ir_noise_filter.sv ----
`timescale 1ns/10ps
`default_nettype none
module ir_noise_filter
	import ir_rx_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic tick,
	input  wire logic wide,
	input  wire logic din,
	output logic      dout
);
	// ----------------------------------------
	// Level must match on 2 or 3 consecutive ticks to pass
	// ----------------------------------------
	logic [1:0] hist_ff;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hist_ff <= 2'b00;
		end else if (tick) begin
			hist_ff <= {hist_ff[0], din};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dout <= 1'b0;
		end else if (tick) begin
			if (!wide && hist_ff[0] == din) begin // R19
				dout <= din;
			end else if (wide && hist_ff[1] == din && hist_ff[0] == din) begin // R19
				dout <= din;
			end
		end
	end
endmodule
`default_nettype wire

// ---- core/ir_remote_pulse_width_receiver.sv ----
// Operation
// R01: New bit enters bit 7, shifts down
// R02: Shift register clears on disable/error/full/end-read
// R03: Software reads shift only after reception
// R04: Full shift copies to data, byte event
// R05: Data register newest bit 7, read-only
// R06: Software reads data before next byte
// R07: Bit count modulo 8, leftover at end
// R08: Bit count clears on disable/error/end-read
// R09: Software reads count before shift register
// R10: Guide high accepted within min/max window
// R11: Data low accepted within min/max window
// R12: High within zero window shifts 0
// R13: High within one window shifts 1
// R14: End width sets trailing low length
// R15: Compare and end registers 8-bit, reset 0
// R16: Software disables before changing compares
// R17: Control register layout at ff60, reset 0
// R18: Control enables, filters, halves, inverts, selects
// R19: Noise filter rejects 1 or 2 periods
// R20: Halve bit divides internal clock by two
// R21: Source select 64/128/256 or subsystem clock
// R22: Invert bit inverts input before measurement
// R23: Width counter restarts at each edge
`timescale 1ns/10ps
`default_nettype none
module ir_remote_pulse_width_receiver
	import ir_rx_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        sub_clk,
	input  wire logic        ir_input,
	input  wire logic [15:0] addr,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [7:0]  wr_data,
	output logic      [7:0]  rd_data,
	output logic             byte_full_event,
	output logic             end_event,
	output logic             error_event,
	output logic             guide_found_event
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]  rc_control_ff;
	logic [7:0]  rc_shift_ff;
	logic [7:0]  rc_byte_data_ff;
	logic [2:0]  rc_bit_count_ff;
	logic [7:0]  guide_high_min_ff;
	logic [7:0]  guide_high_max_ff;
	logic [7:0]  data_low_min_ff;
	logic [7:0]  data_low_max_ff;
	logic [7:0]  zero_high_min_ff;
	logic [7:0]  zero_high_max_ff;
	logic [7:0]  one_high_min_ff;
	logic [7:0]  one_high_max_ff;
	logic [7:0]  end_width_ff;

	logic        receive_enable;
	logic [1:0]  src_sel;
	assign receive_enable = rc_control_ff[BIT_RECEIVE_ENABLE];
	assign src_sel        = rc_control_ff[1:0];

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] ir_sync_ff;
	logic [1:0] sub_sync_ff;
	logic       sub_prev_ff;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ir_sync_ff  <= 2'b00;
			sub_sync_ff <= 2'b00;
			sub_prev_ff <= 1'b0;
		end else begin
			ir_sync_ff  <= {ir_sync_ff[0], ir_input};
			sub_sync_ff <= {sub_sync_ff[0], sub_clk};
			sub_prev_ff <= sub_sync_ff[1];
		end
	end

	// ----------------------------------------
	// Source clock and internal clock ticks
	// ----------------------------------------
	logic [7:0] pre_ff;
	logic       src_tick;
	logic       half_ff;
	logic       int_tick;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pre_ff <= REG_RESET;
		end else begin
			pre_ff <= pre_ff + 8'h01;
		end
	end

	always_comb begin
		// Tick on the carry-out of the selected prescaler stage, or on a synchronised sub_clk rising edge
		if (src_sel == SRC_DIV64) begin // R21
			src_tick = pre_ff[IDX_DIV64:0] == '1;
		end else if (src_sel == SRC_DIV128) begin // R21
			src_tick = pre_ff[IDX_DIV128:0] == '1;
		end else if (src_sel == SRC_DIV256) begin // R21
			src_tick = pre_ff[IDX_DIV256:0] == '1;
		end else begin
			src_tick = sub_sync_ff[1] && !sub_prev_ff; // R21
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || !receive_enable) begin
			half_ff <= 1'b0;
		end else if (src_tick) begin
			half_ff <= ~half_ff;
		end
	end

	assign int_tick = src_tick && (!rc_control_ff[BIT_CLOCK_HALVE] || half_ff); // R20

	// ----------------------------------------
	// Inversion, noise filter, edge detect
	// ----------------------------------------
	logic rx_level;
	logic filt;
	logic filt_prev_ff;
	logic rise;
	logic fall;

	assign rx_level = ir_sync_ff[1] ^ rc_control_ff[BIT_INPUT_INVERT]; // R22

	ir_noise_filter u_filter (
		.ref_clk (ref_clk),
		.rst     (rst),
		.tick    (int_tick),
		.wide    (rc_control_ff[BIT_NOISE_WIDTH_SEL]),
		.din     (rx_level),
		.dout    (filt)
	);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			filt_prev_ff <= 1'b0;
		end else begin
			filt_prev_ff <= filt;
		end
	end

	assign rise = receive_enable && filt && !filt_prev_ff;
	assign fall = receive_enable && !filt && filt_prev_ff;

	// ----------------------------------------
	// Width counter
	// ----------------------------------------
	logic [7:0] width_ff;

	always_ff @(posedge ref_clk) begin
		if (rst || !receive_enable || rise || fall) begin
			width_ff <= REG_RESET; // R23
		end else if (int_tick && width_ff != WIDTH_MAX) begin
			width_ff <= width_ff + 8'h01; // R23
		end
	end

	// ----------------------------------------
	// Reception state machine
	// ----------------------------------------
	rx_state_t  state_ff;
	rx_state_t  nxt_state;
	logic       shift_en;
	logic       shift_bit;
	logic       err;
	logic       guide_ok;
	logic       end_hit;
	logic       ended_ff;
	logic       low_over;
	logic       shift_read;
	logic [8:0] end_limit;

	// Nine bits so the sum cannot wrap; a limit beyond the counter's saturation
	// never ends the frame, and the next edge then ends it with an error
	assign end_limit  = {1'b0, data_low_max_ff} + {1'b0, end_width_ff} + 9'h001; // R14
	assign guide_ok   = width_ff >= guide_high_min_ff && width_ff < guide_high_max_ff; // R10
	assign low_over   = width_ff >= data_low_max_ff;
	assign shift_read = rd_en && addr == ADDR_RC_SHIFT && ended_ff;

	always_comb begin
		nxt_state = state_ff;
		shift_en  = 1'b0;
		shift_bit = 1'b0;
		err       = 1'b0;
		end_hit   = 1'b0;
		case (state_ff)
			ST_GUIDE: begin
				if (fall && guide_ok) begin
					nxt_state = ST_DATA_LOW;
				end
			end
			ST_DATA_LOW: begin
				if (rise) begin
					if (width_ff >= data_low_min_ff && width_ff < data_low_max_ff) begin // R11
						nxt_state = ST_DATA_HI;
					end else begin
						err       = 1'b1;
						nxt_state = ST_GUIDE;
					end
				end else if (low_over) begin
					nxt_state = ST_END_WAIT; // R14
				end
			end
			ST_DATA_HI: begin
				if (fall && width_ff >= zero_high_min_ff && width_ff < zero_high_max_ff) begin // R12
					shift_en  = 1'b1;
					nxt_state = ST_DATA_LOW;
				end else if (fall && width_ff >= one_high_min_ff && width_ff < one_high_max_ff) begin // R13
					shift_en  = 1'b1;
					shift_bit = 1'b1;
					nxt_state = ST_DATA_LOW;
				end else if (fall || width_ff >= one_high_max_ff) begin
					err       = 1'b1;
					nxt_state = ST_GUIDE;
				end
			end
			default: begin
				// Trailing low measured past the data-low maximum
				if (rise && {1'b0, width_ff} < end_limit) begin // R14
					err       = 1'b1;
					nxt_state = ST_GUIDE;
				end else if (!filt && {1'b0, width_ff} >= end_limit) begin // R14
					end_hit   = 1'b1;
					nxt_state = ST_GUIDE;
				end
			end
		endcase
		if (ended_ff) begin
			nxt_state = ST_GUIDE;
			shift_en  = 1'b0;
			err       = 1'b0;
			end_hit   = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || !receive_enable) begin
			state_ff <= ST_GUIDE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Reception halts after the end event until the shift register is read
	always_ff @(posedge ref_clk) begin
		if (rst || !receive_enable) begin
			ended_ff <= 1'b0;
		end else if (end_hit) begin
			ended_ff <= 1'b1;
		end else if (shift_read) begin
			ended_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Shift, count and data registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst || !receive_enable || err || shift_read) begin
			rc_shift_ff     <= REG_RESET; // R02
			rc_bit_count_ff <= COUNT_ZERO; // R08
		end else if (shift_en && rc_bit_count_ff == COUNT_FULL) begin
			rc_shift_ff     <= REG_RESET; // R02
			rc_bit_count_ff <= COUNT_ZERO; // R07
		end else if (shift_en) begin
			rc_shift_ff     <= {shift_bit, rc_shift_ff[7:1]}; // R01
			rc_bit_count_ff <= rc_bit_count_ff + 3'h1; // R07
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || !receive_enable) begin
			rc_byte_data_ff <= REG_RESET; // R05
		end else if (shift_en && rc_bit_count_ff == COUNT_FULL) begin
			rc_byte_data_ff <= {shift_bit, rc_shift_ff[7:1]}; // R04
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			byte_full_event   <= 1'b0;
			end_event         <= 1'b0;
			error_event       <= 1'b0;
			guide_found_event <= 1'b0;
		end else begin
			byte_full_event   <= shift_en && rc_bit_count_ff == COUNT_FULL; // R04
			end_event         <= end_hit;
			error_event       <= err;
			guide_found_event <= state_ff == ST_GUIDE && nxt_state == ST_DATA_LOW; // R10
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rc_control_ff     <= REG_RESET; // R17
			guide_high_min_ff <= REG_RESET; // R15
			guide_high_max_ff <= REG_RESET;
			data_low_min_ff   <= REG_RESET;
			data_low_max_ff   <= REG_RESET;
			zero_high_min_ff  <= REG_RESET;
			zero_high_max_ff  <= REG_RESET;
			one_high_min_ff   <= REG_RESET;
			one_high_max_ff   <= REG_RESET;
			end_width_ff      <= REG_RESET;
		end else if (wr_en) begin
			if (addr == ADDR_RC_CONTROL) begin
				rc_control_ff <= wr_data & CONTROL_WMASK; // R18
			end else if (addr == ADDR_GUIDE_HIGH_MIN) begin
				guide_high_min_ff <= wr_data;
			end else if (addr == ADDR_GUIDE_HIGH_MAX) begin
				guide_high_max_ff <= wr_data;
			end else if (addr == ADDR_DATA_LOW_MIN) begin
				data_low_min_ff <= wr_data;
			end else if (addr == ADDR_DATA_LOW_MAX) begin
				data_low_max_ff <= wr_data;
			end else if (addr == ADDR_ZERO_HIGH_MIN) begin
				zero_high_min_ff <= wr_data;
			end else if (addr == ADDR_ZERO_HIGH_MAX) begin
				zero_high_max_ff <= wr_data;
			end else if (addr == ADDR_ONE_HIGH_MIN) begin
				one_high_min_ff <= wr_data;
			end else if (addr == ADDR_ONE_HIGH_MAX) begin
				one_high_max_ff <= wr_data;
			end else if (addr == ADDR_END_WIDTH) begin
				end_width_ff <= wr_data; // R14
			end
		end
	end

	// ----------------------------------------
	// Register reads, one cycle after rd_en
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_data <= REG_RESET;
		end else if (rd_en) begin
			if (addr == ADDR_RC_CONTROL) begin
				rd_data <= rc_control_ff;
			end else if (addr == ADDR_RC_SHIFT) begin
				rd_data <= rc_shift_ff;
			end else if (addr == ADDR_RC_BYTE_DATA) begin
				rd_data <= rc_byte_data_ff;
			end else if (addr == ADDR_RC_BIT_COUNT) begin
				rd_data <= {5'h00, rc_bit_count_ff};
			end else if (addr == ADDR_GUIDE_HIGH_MIN) begin
				rd_data <= guide_high_min_ff;
			end else if (addr == ADDR_GUIDE_HIGH_MAX) begin
				rd_data <= guide_high_max_ff;
			end else if (addr == ADDR_DATA_LOW_MIN) begin
				rd_data <= data_low_min_ff;
			end else if (addr == ADDR_DATA_LOW_MAX) begin
				rd_data <= data_low_max_ff;
			end else if (addr == ADDR_ZERO_HIGH_MIN) begin
				rd_data <= zero_high_min_ff;
			end else if (addr == ADDR_ZERO_HIGH_MAX) begin
				rd_data <= zero_high_max_ff;
			end else if (addr == ADDR_ONE_HIGH_MIN) begin
				rd_data <= one_high_min_ff;
			end else if (addr == ADDR_ONE_HIGH_MAX) begin
				rd_data <= one_high_max_ff;
			end else if (addr == ADDR_END_WIDTH) begin
				rd_data <= end_width_ff;
			end else begin
				rd_data <= REG_RESET;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_shift_insert: assert property (@(posedge ref_clk) disable iff (rst) // R01
		shift_en && rc_bit_count_ff != COUNT_FULL && !err && !shift_read && receive_enable
		|=> rc_shift_ff[7] == $past(shift_bit) && rc_shift_ff[6:0] == $past(rc_shift_ff[7:1]))
		else $error("shift insert wrong");
	a_disable_clear: assert property (@(posedge ref_clk) disable iff (rst) // R02
		!receive_enable |=> rc_shift_ff == REG_RESET && rc_bit_count_ff == COUNT_ZERO)
		else $error("disable did not clear");
	a_byte_transfer: assert property (@(posedge ref_clk) disable iff (rst) // R04
		receive_enable && shift_en && rc_bit_count_ff == COUNT_FULL
		|=> byte_full_event && rc_byte_data_ff == {$past(shift_bit), $past(rc_shift_ff[7:1])})
		else $error("byte transfer wrong");
	a_count_step: assert property (@(posedge ref_clk) disable iff (rst) // R07
		receive_enable && shift_en && !err && !shift_read
		|=> rc_bit_count_ff == $past(rc_bit_count_ff) + 3'h1)
		else $error("bit count wrong");
	a_error_clear: assert property (@(posedge ref_clk) disable iff (rst) // R08
		err |=> rc_bit_count_ff == COUNT_ZERO && rc_shift_ff == REG_RESET ##1 !error_event)
		else $error("error did not clear");
	a_guide_window: assert property (@(posedge ref_clk) disable iff (rst) // R10
		guide_found_event |-> $past(width_ff) >= $past(guide_high_min_ff)
		&& $past(width_ff) < $past(guide_high_max_ff))
		else $error("guide outside window");
	a_width_restart: assert property (@(posedge ref_clk) disable iff (rst) // R23
		rise || fall |=> width_ff == REG_RESET)
		else $error("width not restarted");
	a_ctrl_reserved: assert property (@(posedge ref_clk) disable iff (rst) // R17
		rc_control_ff[3:2] == 2'b00)
		else $error("reserved control bits set");
endmodule
`default_nettype wire

// ---- tb/ir_remote_source.sv ----
`timescale 1ns/10ps
`default_nettype none
module ir_remote_source (
	input  wire logic ref_clk,
	output logic      ir_line
);
	// ----------------------------------------
	// Demodulated remote waveform source
	// ----------------------------------------
	// Widths are in receiver ticks; unit is ref_clk cycles per tick
	int   unit;
	logic invert;

	initial begin
		unit = 64;
		invert = 1'b0;
		ir_line = 1'b0;
	end

	task automatic hold(input logic lvl, input int ticks);
		// Level changes the same 1 ns after an edge and lasts ticks*unit cycles
		@(posedge ref_clk);
		#1 ir_line = lvl ^ invert;
		repeat (ticks * unit - 1) @(posedge ref_clk);
	endtask

	// Guide high, then low/high per bit, then a trailing low long enough to end
	task automatic frame(input logic [8:0] bits);
		hold(1'b1, 12);
		for (int i = 0; i < 9; i++) begin
			hold(1'b0, 5);
			hold(1'b1, bits[i] ? 11 : 5);
		end
		hold(1'b0, 16);
	endtask
endmodule
`default_nettype wire

// ---- tb/ir_remote_pulse_width_receiver_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module ir_remote_pulse_width_receiver_tb
	import ir_rx_pkg::*;
;
	logic        ref_clk;
	logic        rst;
	logic        sub_clk;
	logic        ir_input;
	logic [15:0] addr;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  wr_data;
	logic [7:0]  rd_data;
	logic        byte_full_event;
	logic        end_event;
	logic        error_event;
	logic        guide_found_event;
	logic [7:0]  exp_q[$];
	logic        rd_seen;
	logic [7:0]  v;
	logic [8:0]  bits;
	int          miscompares;
	int          check_count;
	int          cycles;
	logic [7:0]  cmp_val[9] = '{8'h08, 8'h10, 8'h03, 8'h07, 8'h03, 8'h07, 8'h09, 8'h0e, 8'h02};
	logic [7:0]  ctrls[4]   = '{8'h80, 8'h91, 8'he0, 8'h83};
	int          units[4]   = '{64, 128, 128, 81};

	ir_remote_pulse_width_receiver i_dut (
		.ref_clk          (ref_clk),
		.rst              (rst),
		.sub_clk          (sub_clk),
		.ir_input         (ir_input),
		.addr             (addr),
		.wr_en            (wr_en),
		.rd_en            (rd_en),
		.wr_data          (wr_data),
		.rd_data          (rd_data),
		.byte_full_event  (byte_full_event),
		.end_event        (end_event),
		.error_event      (error_event),
		.guide_found_event(guide_found_event)
	);

	ir_remote_source i_src (
		.ref_clk(ref_clk),
		.ir_line(ir_input)
	);

	// ----------------------------------------
	// Clocks and watchdog
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Subsystem clock kept out of phase with ref_clk on purpose
	initial begin
		sub_clk = 1'b0;
		forever #201.3 sub_clk = ~sub_clk;
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 90000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic take(input string name, input logic [7:0] seen);
		if (exp_q.size() == 0) begin
			miscompares++;
			$display("[FAIL] %s expected nothing seen %h", name, seen);
		end else
			check(name, exp_q.pop_front(), seen);
	endtask

	// Results are taken one edge after they were launched, so values are settled
	always @(posedge ref_clk) begin
		if (!rst) begin
			if (rd_seen)
				take("rd_data", rd_data);
			if ({error_event, end_event, byte_full_event, guide_found_event} !== 4'h0)
				take("events", {4'h0, error_event, end_event, byte_full_event, guide_found_event});
		end
		rd_seen = rd_en;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Register bus driver
	// ----------------------------------------
	task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		addr = a;
		wr_data = d;
		wr_en = 1'b1;
		@(posedge ref_clk);
		#1 wr_en = 1'b0;
	endtask

	task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		#1;
		addr = a;
		rd_en = 1'b1;
		exp_q.push_back(exp);
		@(posedge ref_clk);
		#1 rd_en = 1'b0;
	endtask

	task automatic drain();
		while (exp_q.size() != 0)
			@(posedge ref_clk);
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		addr = 16'h0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wr_data = 8'h00;
		rd_seen = 1'b0;
		miscompares = 0;
		check_count = 0;
		cycles = 0;
		void'($urandom(32'h1440));
		repeat (12) @(posedge ref_clk);
		#1 rst = 1'b0;

		for (int i = 0; i < 13; i++)
			reg_rd(ADDR_RC_CONTROL + 16'(i), REG_RESET);
		reg_rd(16'hff70, 8'h00);
		drain();
		$display("test reset_values done");

		for (int i = 4; i < 13; i++) begin
			v = 8'($urandom);
			reg_wr(ADDR_RC_CONTROL + 16'(i), v);
			reg_rd(ADDR_RC_CONTROL + 16'(i), v);
		end
		reg_wr(ADDR_RC_CONTROL, 8'hff);
		reg_rd(ADDR_RC_CONTROL, 8'hf3);
		reg_wr(ADDR_RC_CONTROL, 8'h00);
		reg_wr(ADDR_RC_BYTE_DATA, 8'h5a);
		reg_rd(ADDR_RC_BYTE_DATA, 8'h00);
		for (int i = 0; i < 9; i++)
			reg_wr(ADDR_GUIDE_HIGH_MIN + 16'(i), cmp_val[i]);
		drain();
		$display("test register_access done");

		for (int c = 0; c < 4; c++) begin
			reg_wr(ADDR_RC_CONTROL, 8'h00);
			i_src.unit = units[c];
			i_src.invert = ctrls[c][BIT_INPUT_INVERT];
			i_src.hold(1'b0, 4);
			reg_wr(ADDR_RC_CONTROL, ctrls[c]);
			bits = 9'($urandom);
			exp_q.push_back(8'h01);
			exp_q.push_back(8'h02);
			exp_q.push_back(8'h04);
			i_src.frame(bits);
			drain();
			reg_rd(ADDR_RC_BIT_COUNT, 8'h01);
			reg_rd(ADDR_RC_BYTE_DATA, bits[7:0]);
			reg_rd(ADDR_RC_SHIFT, {bits[8], 7'h00});
			reg_rd(ADDR_RC_SHIFT, 8'h00);
			reg_rd(ADDR_RC_BIT_COUNT, 8'h00);
			drain();
			$display("test frame config %0d done", c);
		end

		// A too-short data low after one good bit must raise an error
		reg_wr(ADDR_RC_CONTROL, 8'h00);
		i_src.unit = 64;
		i_src.invert = 1'b0;
		i_src.hold(1'b0, 4);
		reg_wr(ADDR_RC_CONTROL, 8'h80);
		exp_q.push_back(8'h01);
		exp_q.push_back(8'h08);
		i_src.hold(1'b1, 12);
		i_src.hold(1'b0, 5);
		i_src.hold(1'b1, 5);
		i_src.hold(1'b0, 2);
		i_src.hold(1'b1, 5);
		i_src.hold(1'b0, 16);
		// A data high between the zero and one windows must also raise an error
		exp_q.push_back(8'h01);
		exp_q.push_back(8'h08);
		i_src.hold(1'b1, 12);
		i_src.hold(1'b0, 5);
		i_src.hold(1'b1, 8);
		i_src.hold(1'b0, 16);
		drain();
		reg_rd(ADDR_RC_BIT_COUNT, 8'h00);
		reg_rd(ADDR_RC_SHIFT, 8'h00);
		reg_wr(ADDR_RC_CONTROL, 8'h00);
		reg_rd(ADDR_RC_BYTE_DATA, 8'h00);
		drain();
		$display("test error_and_disable done");
		wrap_up();
	end
endmodule
`default_nettype wire
